// *** common/fbeb_pkg.sv ***
// Purpose: shared constants and carriers for the event buffer bus slave
// Assumes: registers reached through a simplified parallel slave port
// Notes: secondary address values are the register numbers
package fbeb_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int PAGE_W = 3;
    localparam int WORD_W = 11;
    localparam int MEM_AW = PAGE_W + WORD_W;
    localparam int MEM_WORDS = 16384;
    localparam int PAGE_WORDS = 2048;
    localparam int MAX_EVENT_WORDS = 1537;
    // secondary addresses in control space
    localparam logic [31:0] SA_CTRL0 = 32'h00000000;
    localparam logic [31:0] SA_LOGICAL = 32'h00000003;
    localparam logic [31:0] SA_WCOUNT = 32'h00000005;
    localparam logic [31:0] SA_CLASS = 32'h00000007;
    localparam logic [31:0] SA_PTRS = 32'h00000010;
    localparam int CTRL0_ADVANCE_BIT = 10;
    localparam int CTRL0_RAWMODE_BIT = 1;
    localparam int LA_LSB = 16;
    localparam int RDPTR_LSB = 8;
    localparam logic [2:0] RDPTR_RESET = 3'h7;
    localparam logic [2:0] WRPTR_RESET = 3'h0;
    localparam logic [31:0] BC_GENERAL = 32'h00000001;
    localparam logic [31:0] BC_SPARSE = 32'h00000009;
    localparam logic [31:0] BC_AVAIL = 32'h00000019;
    localparam logic [31:0] BC_ALL_T = 32'h0000000D;
    localparam logic [31:0] BC_UNSUP = 32'h000000CD;
    localparam logic [3:0] BC_CLASS_NIB = 4'h5;
    localparam logic [1:0] SS_OK = 2'h0;
    localparam logic [1:0] SS_END = 2'h2;
    localparam int HANDSHAKE_NS = 500;
    localparam int CLK_NS = 10;
    localparam int HANDSHAKE_CYC = HANDSHAKE_NS / CLK_NS;
    localparam int DECODE_CYC = 2;
    // header word: count 10:0, buffer 13:11, phase 14, parity 23, addr 31:24
    localparam int HDR_BUF_LSB = 11;
    localparam int HDR_PHASE_BIT = 14;
    localparam int HDR_PAR_BIT = 23;
    localparam int HDR_ADDR_LSB = 24;
    // data word: time 15:0, phase 16, channel 23:17, hits 25:24,
    // parity 26, address 31:27
    localparam int DW_PHASE_BIT = 16;
    localparam int DW_CHAN_LSB = 17;
    localparam int DW_HITS_LSB = 24;
    localparam int DW_PAR_BIT = 26;
    localparam int DW_ADDR_LSB = 27;

    typedef struct packed {
        logic [15:0] timeVal;
        logic phase;
        logic [6:0] channel;
        logic [1:0] hits;
    } fbeb_hit_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic ctrlSpace;
        logic [31:0] data;
    } fbeb_bus_t;
endpackage : fbeb_pkg

// *** hw/fbeb_mem.sv ***
// Purpose: event store with registered read data
// Assumes: one port, write has priority
// Notes: depth follows the address width
`timescale 1ns/1ps
module fbeb_mem #(
    parameter int AW = 14,
    parameter int DW = 32
) (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] store [0:(1<<AW)-1];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            store[addr] <= wdata;
        end
        rdata <= store[addr];
    end
endmodule : fbeb_mem

// *** hw/fastbus_event_buffer_slave.sv ***
// Purpose: bus slave of an eight page multi-event time digitizer buffer
// Assumes: bus cycles arrive as one-cycle strobes synchronous to sys_clk
// Notes: front end presents words and an event-done pulse
`timescale 1ns/1ps
module fastbus_event_buffer_slave #(
    parameter int DECODE_CYCLES = fbeb_pkg::DECODE_CYC,
    parameter logic [4:0] GEO_ADDR = 5'h01
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic addrStrobe,
    input wire logic addrCtrlSpace,
    input wire logic [31:0] addrIn,
    input wire logic [4:0] geoAddrIn,
    input wire logic geoSelect,
    input wire fbeb_pkg::fbeb_bus_t dataCycle,
    input wire logic [31:0] secAddr,
    input wire logic blockMode,
    input wire fbeb_pkg::fbeb_hit_t hitIn,
    input wire logic hitValid,
    input wire logic hitUnsuppressed,
    input wire logic eventDone,
    input wire logic eventPhase,
    input wire logic [1:0] edgeEnable,
    output logic selected,
    output logic waitOut,
    output logic tPin,
    output logic [31:0] readData,
    output logic readValid,
    output logic [1:0] slaveStatus,
    output logic buffering_in_progress,
    output logic bufEmpty,
    output logic bufFull
);
    typedef enum logic [4:0] {
        SCAN_NONE = 5'h01,
        SCAN_DATA = 5'h02,
        SCAN_AVAIL = 5'h04,
        SCAN_ALL = 5'h08,
        SCAN_UNSUP = 5'h10
    } fbeb_scan_t;

    logic [31:0] logicalAddress;
    logic [3:0] classEnable;
    logic [2:0] rdPtr;
    logic [2:0] wrPtr;
    logic [10:0] wordCount;
    logic rawMode;
    logic unsupSeen;
    logic [7:0] pageUnsup;
    fbeb_scan_t scanMode;
    logic isBroadcast;
    logic [7:0] decodeCnt;
    logic [10:0] fillIdx;
    logic memWe;
    logic [13:0] memAddr;
    logic [31:0] memWdata;
    logic [31:0] memRdata;
    logic rdPend;
    logic [31:0] regRead;
    logic regSel;
    logic [2:0] rdNext;
    logic dcData;
    logic dcRead;
    logic dcWrite;
    logic liveAddr;
    logic wcVisible;
    logic advLoad;
    logic hdrLoad;
    logic [10:0] blkIdx;

    function automatic logic evenPar(input logic [31:0] w);
        evenPar = ^w;
    endfunction : evenPar

    function automatic logic saIs(input logic [31:0] a,
                                  input logic [31:0] b);
        saIs = (a == b);
    endfunction : saIs

    assign rdNext = rdPtr + 3'h1;
    assign bufEmpty = (rdPtr == wrPtr - 3'h1);
    assign bufFull = (rdPtr == wrPtr);
    assign dcRead = dataCycle.valid && !dataCycle.write && selected;
    assign dcWrite = dataCycle.valid && dataCycle.write && selected;
    assign dcData = !dataCycle.ctrlSpace;
    assign wcVisible = rawMode;
    // only address zero is live until the raw window is opened
    assign liveAddr = rawMode || (secAddr[10:0] == 11'h000);

    // primary address decode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            selected <= 1'b0;
            isBroadcast <= 1'b0;
            scanMode <= SCAN_NONE;
        end else if (addrStrobe) begin
            isBroadcast <= 1'b0;
            scanMode <= SCAN_NONE;
            if (geoSelect && geoAddrIn == GEO_ADDR) begin
                selected <= 1'b1;
            end else if (geoSelect) begin
                // a geographic cycle for another slot never falls through
                selected <= 1'b0;
            end else if (addrIn[31:8] != 24'h000000 &&
                         addrIn[31:16] ==
                         logicalAddress[31:16]) begin
                selected <= 1'b1;
            end else if (addrIn == fbeb_pkg::BC_GENERAL) begin
                selected <= 1'b1;
                isBroadcast <= 1'b1;
            end else if (addrIn[31:8] == 24'h000000 &&
                         addrIn[3:0] == fbeb_pkg::BC_CLASS_NIB &&
                         addrIn[7:6] == 2'h0) begin
                selected <= classEnable[addrIn[5:4]];
                isBroadcast <= 1'b1;
            end else if (addrIn == fbeb_pkg::BC_SPARSE) begin
                selected <= 1'b1;
                isBroadcast <= 1'b1;
                scanMode <= SCAN_DATA;
            end else if (addrIn == fbeb_pkg::BC_AVAIL) begin
                selected <= 1'b1;
                isBroadcast <= 1'b1;
                scanMode <= SCAN_AVAIL;
            end else if (addrIn == fbeb_pkg::BC_ALL_T) begin
                selected <= 1'b1;
                isBroadcast <= 1'b1;
                scanMode <= SCAN_ALL;
            end else if (addrIn == fbeb_pkg::BC_UNSUP) begin
                selected <= 1'b1;
                isBroadcast <= 1'b1;
                scanMode <= SCAN_UNSUP;
            end else begin
                selected <= 1'b0;
            end
        end
    end

    // broadcast decode takes a few cycles; hold wait meanwhile
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            decodeCnt <= 8'h00;
        end else if (addrStrobe && !geoSelect &&
                     addrIn[31:8] == 24'h000000) begin
            decodeCnt <= 8'(DECODE_CYCLES);
        end else if (decodeCnt != 8'h00) begin
            decodeCnt <= decodeCnt - 8'h01;
        end
    end
    assign waitOut = (decodeCnt != 8'h00);

    // T-pin answer during the read cycle following a scan broadcast
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tPin <= 1'b0;
        end else if (dcRead) begin
            case (scanMode)
                // the address lines are gone by now, so the mode says it all
                SCAN_DATA: tPin <= !bufEmpty;
                SCAN_UNSUP: tPin <= !bufEmpty && pageUnsup[rdNext];
                SCAN_AVAIL: tPin <= bufEmpty;
                SCAN_ALL: tPin <= 1'b1;
                SCAN_NONE: tPin <= 1'b0;
                default: tPin <= 1'b0;
            endcase
        end else begin
            tPin <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            logicalAddress <= 32'h00000000;
            classEnable <= 4'h0;
            rawMode <= 1'b0;
        end else if (dcWrite && dataCycle.ctrlSpace) begin
            if (saIs(secAddr, fbeb_pkg::SA_LOGICAL)) begin
                logicalAddress <= {dataCycle.data[31:16], 16'h0000};
            end
            if (saIs(secAddr, fbeb_pkg::SA_CLASS)) begin
                classEnable <= dataCycle.data[3:0];
            end
            if (saIs(secAddr, fbeb_pkg::SA_CTRL0)) begin
                rawMode <= dataCycle.data[fbeb_pkg::CTRL0_RAWMODE_BIT];
            end
        end
    end

    // pointers, word count and fill index
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdPtr <= fbeb_pkg::RDPTR_RESET;
            wrPtr <= fbeb_pkg::WRPTR_RESET;
            wordCount <= 11'h000;
            fillIdx <= 11'h001;
            unsupSeen <= 1'b0;
            pageUnsup <= 8'h00;
        end else begin
            if (hitValid && !bufFull && fillIdx <= 11'(1536)) begin
                fillIdx <= fillIdx + 11'h001;
                unsupSeen <= unsupSeen | hitUnsuppressed;
            end
            if (eventDone && !bufFull && memWe) begin
                wrPtr <= wrPtr + 3'h1;
                pageUnsup[wrPtr] <= unsupSeen;
                fillIdx <= 11'h001;
                unsupSeen <= 1'b0;
            end
            if (dcWrite && dataCycle.ctrlSpace &&
                saIs(secAddr, fbeb_pkg::SA_CTRL0) &&
                dataCycle.data[fbeb_pkg::CTRL0_ADVANCE_BIT]) begin
                rdPtr <= rdNext;
                // count stays clear until the header read returns
                wordCount <= 11'h000;
            end else if (dcWrite && dataCycle.ctrlSpace &&
                         saIs(secAddr, fbeb_pkg::SA_PTRS)) begin
                rdPtr <= dataCycle.data[10:8];
                wrPtr <= dataCycle.data[2:0];
            end else if (dcWrite && dataCycle.ctrlSpace && wcVisible &&
                         saIs(secAddr, fbeb_pkg::SA_WCOUNT)) begin
                wordCount <= dataCycle.data[10:0];
            end else if (hdrLoad) begin
                wordCount <= memRdata[10:0];
            end else if (dcRead && dcData && blockMode &&
                         wordCount != 11'h000) begin
                wordCount <= wordCount - 11'h001;
            end
        end
    end

    // header load is fetched from word zero right after an advance;
    // its data stand a cycle later, when the count is loaded
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            advLoad <= 1'b0;
            hdrLoad <= 1'b0;
        end else begin
            hdrLoad <= advLoad;
            advLoad <= dcWrite && dataCycle.ctrlSpace &&
                saIs(secAddr, fbeb_pkg::SA_CTRL0) &&
                dataCycle.data[fbeb_pkg::CTRL0_ADVANCE_BIT];
        end
    end

    // block read walks the page upward from the header
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            blkIdx <= 11'h000;
        end else if (advLoad || addrStrobe) begin
            blkIdx <= 11'h000;
        end else if (dcRead && dcData && blockMode &&
                     wordCount != 11'h000) begin
            blkIdx <= blkIdx + 11'h001;
        end
    end

    // buffering flag set while every page is occupied or a hit is arriving
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buffering_in_progress <= 1'b0;
        end else begin
            buffering_in_progress <= bufFull || hitValid;
        end
    end

    // memory port: front end fill, header write, bus access
    logic [31:0] hdrWord;
    logic [31:0] dataWord;
    always_comb begin
        hdrWord = 32'h00000000;
        hdrWord[10:0] = fillIdx;
        hdrWord[13:11] = wrPtr;
        hdrWord[fbeb_pkg::HDR_PHASE_BIT] = eventPhase;
        hdrWord[31:24] = {3'h0, GEO_ADDR};
        hdrWord[fbeb_pkg::HDR_PAR_BIT] = evenPar(hdrWord);
        dataWord = 32'h00000000;
        dataWord[15:0] = hitIn.timeVal;
        dataWord[fbeb_pkg::DW_PHASE_BIT] = hitIn.phase;
        dataWord[23:17] = hitIn.channel;
        // two-bit hit count passed through, forced to zero when no edge is enabled
        dataWord[25:24] = (edgeEnable == 2'h0) ? 2'h0 : hitIn.hits;
        dataWord[31:27] = GEO_ADDR;
        dataWord[fbeb_pkg::DW_PAR_BIT] = evenPar(dataWord);
        memWe = 1'b0;
        memAddr = {rdPtr, secAddr[10:0]};
        memWdata = dataCycle.data;
        if (eventDone && !bufFull) begin
            memWe = 1'b1;
            memAddr = {wrPtr, 11'h000};
            memWdata = hdrWord;
        end else if (hitValid && !bufFull && fillIdx <= 11'(1536)) begin
            memWe = 1'b1;
            memAddr = {wrPtr, fillIdx};
            memWdata = dataWord;
        end else if (advLoad) begin
            memAddr = {rdPtr, 11'h000};
        end else if (dcData && dataCycle.valid && selected &&
                     blockMode) begin
            memAddr = {rdPtr, blkIdx};
        end else if (dcWrite && dcData && rawMode && !blockMode) begin
            memWe = 1'b1;
        end
    end

    fbeb_mem #(
        .AW(fbeb_pkg::MEM_AW),
        .DW(fbeb_pkg::DATA_W)
    ) u_mem (
        .sys_clk(sys_clk),
        .we(memWe),
        .addr(memAddr),
        .wdata(memWdata),
        .rdata(memRdata)
    );

    always_comb begin
        regSel = 1'b1;
        regRead = 32'h00000000;
        case (secAddr)
            fbeb_pkg::SA_LOGICAL: regRead = logicalAddress;
            fbeb_pkg::SA_CLASS: regRead = {28'h0000000, classEnable};
            fbeb_pkg::SA_PTRS: regRead = {21'h000000, rdPtr, 5'h00, wrPtr};
            fbeb_pkg::SA_WCOUNT: regRead = wcVisible ?
                {21'h000000, wordCount} : 32'h00000000;
            fbeb_pkg::SA_CTRL0: regRead = {30'h00000000, rawMode, 1'b0};
            default: regSel = 1'b0;
        endcase
    end

    // read data path; memory answers one cycle later
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdPend <= 1'b0;
            readData <= 32'h00000000;
            readValid <= 1'b0;
            slaveStatus <= fbeb_pkg::SS_OK;
        end else begin
            rdPend <= (dcRead && dcData && liveAddr) || advLoad;
            readValid <= 1'b0;
            slaveStatus <= fbeb_pkg::SS_OK;
            if (dcRead && dataCycle.ctrlSpace) begin
                readData <= regSel ? regRead : 32'h00000000;
                readValid <= 1'b1;
            end else if (dcRead && dcData && !liveAddr) begin
                readData <= 32'h00000000;
                readValid <= 1'b1;
            end else if (rdPend && !hdrLoad) begin
                readData <= memRdata;
                readValid <= 1'b1;
                if (blockMode && wordCount == 11'h000) begin
                    slaveStatus <= fbeb_pkg::SS_END;
                end
            end
        end
    end

    a_wait_bound: assert property (
        @(posedge sys_clk) disable iff (rst)
        waitOut |-> ##[0:20] !waitOut)
        else $error("wait held too long");
    a_full_flag: assert property (
        @(posedge sys_clk) disable iff (rst)
        bufFull |=> buffering_in_progress)
        else $error("buffering flag missing while full");
    a_ptr_step: assert property (
        @(posedge sys_clk) disable iff (rst)
        (eventDone && !bufFull && !(dcWrite && dataCycle.ctrlSpace))
        |=> wrPtr == $past(wrPtr) + 3'h1)
        else $error("write pointer did not step");
    a_empty_full: assert property (
        @(posedge sys_clk) disable iff (rst)
        !(bufEmpty && bufFull))
        else $error("empty and full together");
    a_scan_all: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dcRead && scanMode == SCAN_ALL) |=> tPin)
        else $error("t pin missing after 0D");
    a_scan_avail: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dcRead && scanMode == SCAN_AVAIL) |=> tPin == $past(bufEmpty))
        else $error("availability reply wrong");
    a_wc_hidden: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dcRead && dataCycle.ctrlSpace && !rawMode &&
        secAddr == fbeb_pkg::SA_WCOUNT) |=> readData == 32'h00000000)
        else $error("word count visible outside raw mode");
    a_end_status: assert property (
        @(posedge sys_clk) disable iff (rst)
        slaveStatus == fbeb_pkg::SS_END |-> readValid)
        else $error("end status without data");
endmodule : fastbus_event_buffer_slave

// *** tb/fbeb_master.sv ***
// Purpose: bus master model issuing address and data cycles
// Assumes: requests change at the falling edge as one-cycle strobes
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ps
module fbeb_master (
    input wire logic sys_clk,
    output logic addrStrobe,
    output logic addrCtrlSpace,
    output logic [31:0] addrIn,
    output logic [4:0] geoAddrIn,
    output logic geoSelect,
    output fbeb_pkg::fbeb_bus_t dataCycle,
    output logic [31:0] secAddr,
    input wire logic waitOut,
    input wire logic tPin,
    input wire logic [31:0] readData,
    input wire logic readValid,
    input wire logic [1:0] slaveStatus
);
    logic [31:0] rdData;
    logic tSeen;
    logic endSeen;
    logic waitSeen;

    initial begin
        addrStrobe = 1'b0;
        addrCtrlSpace = 1'b0;
        addrIn = 32'h0;
        geoAddrIn = 5'h0;
        geoSelect = 1'b0;
        dataCycle = '0;
        secAddr = 32'h0;
    end

    task automatic addr(input logic geo, input logic [31:0] a,
                        input logic ctrl);
        int n;
        @(negedge sys_clk);
        geoSelect = geo;
        geoAddrIn = a[4:0];
        addrIn = a;
        addrCtrlSpace = ctrl;
        addrStrobe = 1'b1;
        @(negedge sys_clk);
        addrStrobe = 1'b0;
        geoSelect = 1'b0;
        addrIn = ~a;
        waitSeen = 1'b0;
        // slow decodes stretch the handshake, so never start data early
        for (n = 0; n < 60; n++) begin
            @(negedge sys_clk);
            if (waitOut === 1'b1) begin
                waitSeen = 1'b1;
            end else if (n > fbeb_pkg::DECODE_CYC) begin
                break;
            end
        end
    endtask : addr

    task automatic xfer(input logic w, input logic ctrl,
                        input logic [31:0] sa, input logic [31:0] d);
        rdData = 32'hA5A5A5A5;
        tSeen = 1'b0;
        endSeen = 1'b0;
        @(negedge sys_clk);
        dataCycle = '{1'b1, w, ctrl, d};
        secAddr = sa;
        @(negedge sys_clk);
        dataCycle = '{1'b0, w, ctrl, ~d};
        secAddr = ~sa;
        // register answers stand one cycle on, memory answers two
        repeat (3) begin
            if (readValid === 1'b1) rdData = readData;
            if (tPin === 1'b1) tSeen = 1'b1;
            if (slaveStatus === fbeb_pkg::SS_END) endSeen = 1'b1;
            @(negedge sys_clk);
        end
    endtask : xfer
endmodule : fbeb_master

// *** tb/fastbus_event_buffer_slave_tb.sv ***
// Purpose: self-checking bench for the event buffer bus slave
// Assumes: master model drives the bus, bench drives the front end
// Notes: inputs change at the falling clock edge
`timescale 1ns/1ps
module fastbus_event_buffer_slave_tb;
    localparam logic [4:0] GEO = 5'h0A;
    logic sys_clk, rst, addrStrobe, addrCtrlSpace, geoSelect, blockMode;
    logic hitValid, hitUnsuppressed, eventDone, eventPhase, waitOut, tPin;
    logic selected, readValid, buffering_in_progress, bufEmpty, bufFull;
    logic [31:0] addrIn, secAddr, readData;
    logic [4:0] geoAddrIn;
    logic [1:0] edgeEnable, slaveStatus;
    fbeb_pkg::fbeb_bus_t dataCycle;
    fbeb_pkg::fbeb_hit_t hitIn;
    fbeb_pkg::fbeb_hit_t hits [2];
    int n_fail, checked;

    fastbus_event_buffer_slave #(.GEO_ADDR(GEO)) i_fastbus_event_buffer_slave (
        .sys_clk(sys_clk), .rst(rst), .addrStrobe(addrStrobe),
        .addrCtrlSpace(addrCtrlSpace), .addrIn(addrIn),
        .geoAddrIn(geoAddrIn), .geoSelect(geoSelect),
        .dataCycle(dataCycle), .secAddr(secAddr), .blockMode(blockMode),
        .hitIn(hitIn), .hitValid(hitValid),
        .hitUnsuppressed(hitUnsuppressed), .eventDone(eventDone),
        .eventPhase(eventPhase), .edgeEnable(edgeEnable),
        .selected(selected), .waitOut(waitOut), .tPin(tPin),
        .readData(readData), .readValid(readValid),
        .slaveStatus(slaveStatus),
        .buffering_in_progress(buffering_in_progress),
        .bufEmpty(bufEmpty), .bufFull(bufFull));

    fbeb_master i_fbeb_master (
        .sys_clk(sys_clk), .addrStrobe(addrStrobe),
        .addrCtrlSpace(addrCtrlSpace), .addrIn(addrIn),
        .geoAddrIn(geoAddrIn), .geoSelect(geoSelect),
        .dataCycle(dataCycle), .secAddr(secAddr), .waitOut(waitOut),
        .tPin(tPin), .readData(readData), .readValid(readValid),
        .slaveStatus(slaveStatus));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checked %0d, n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic reg_wr(input logic [31:0] sa, input logic [31:0] d);
        i_fbeb_master.addr(1'b1, {27'h0, GEO}, 1'b1);
        i_fbeb_master.xfer(1'b1, 1'b1, sa, d);
    endtask : reg_wr

    task automatic reg_rd(input logic [31:0] sa, input logic [31:0] exp);
        i_fbeb_master.addr(1'b1, {27'h0, GEO}, 1'b1);
        i_fbeb_master.xfer(1'b0, 1'b1, sa, 32'h0);
        check(i_fbeb_master.rdData, exp);
    endtask : reg_rd

    task automatic sel_is(input logic [31:0] a, input logic geo,
                          input logic exp);
        i_fbeb_master.addr(geo, a, 1'b1);
        check({31'h0, selected}, {31'h0, exp});
    endtask : sel_is

    task automatic scan(input logic [31:0] code, input logic exp);
        i_fbeb_master.addr(1'b0, code, 1'b0);
        i_fbeb_master.xfer(1'b0, 1'b0, 32'h0, 32'h0);
        check({31'h0, i_fbeb_master.tSeen}, {31'h0, exp});
    endtask : scan

    task automatic store(input int nHits);
        for (int k = 0; k < nHits; k++) begin
            @(negedge sys_clk);
            hitIn = hits[k];
            hitValid = 1'b1;
            @(negedge sys_clk);
            hitValid = 1'b0;
        end
        @(negedge sys_clk);
        eventDone = 1'b1;
        @(negedge sys_clk);
        eventDone = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : store

    task automatic test_reset;
        check({31'h0, bufEmpty}, 32'h1);
        reg_rd(fbeb_pkg::SA_PTRS, 32'h00000700);
        i_fbeb_master.addr(1'b1, {27'h0, GEO}, 1'b0);
        i_fbeb_master.xfer(1'b1, 1'b0, 32'h3, 32'h12345678);
        i_fbeb_master.xfer(1'b0, 1'b0, 32'h3, 32'h0);
        check(i_fbeb_master.rdData, 32'h0);
    endtask : test_reset

    task automatic test_addressing;
        reg_wr(fbeb_pkg::SA_LOGICAL, 32'h5A3C0000);
        sel_is(32'h5A3C0011, 1'b0, 1'b1);
        sel_is(32'h5A3D0000, 1'b0, 1'b0);
        sel_is({27'h0, GEO ^ 5'h01}, 1'b1, 1'b0);
        sel_is({27'h0, GEO}, 1'b1, 1'b1);
        reg_wr(fbeb_pkg::SA_CLASS, 32'h00000004);
        for (int n = 0; n < 4; n++) begin
            sel_is({24'h0, 4'(n), 4'h5}, 1'b0, n == 2);
        end
        sel_is(fbeb_pkg::BC_GENERAL, 1'b0, 1'b1);
        check({31'h0, i_fbeb_master.waitSeen}, 32'h1);
    endtask : test_addressing

    task automatic test_readout;
        logic [31:0] w [3];
        logic ended;
        scan(fbeb_pkg::BC_SPARSE, 1'b0);
        scan(fbeb_pkg::BC_AVAIL, 1'b1);
        scan(fbeb_pkg::BC_ALL_T, 1'b1);
        store(2);
        reg_rd(fbeb_pkg::SA_PTRS, 32'h00000701);
        check({31'h0, bufEmpty}, 32'h0);
        scan(fbeb_pkg::BC_SPARSE, 1'b1);
        scan(fbeb_pkg::BC_UNSUP, 1'b1);
        reg_wr(fbeb_pkg::SA_CTRL0, 32'h00000400);
        reg_rd(fbeb_pkg::SA_PTRS, 32'h00000001);
        i_fbeb_master.addr(1'b1, {27'h0, GEO}, 1'b0);
        blockMode = 1'b1;
        ended = 1'b0;
        for (int k = 0; k < 3; k++) begin
            i_fbeb_master.xfer(1'b0, 1'b0, 32'h0, 32'h0);
            w[k] = i_fbeb_master.rdData;
            ended = ended | i_fbeb_master.endSeen;
        end
        blockMode = 1'b0;
        check({21'h0, w[0][10:0]}, 32'h3);
        check({29'h0, w[0][13:11]}, 32'h0);
        check({31'h0, ^w[0]}, 32'h0);
        for (int k = 0; k < 2; k++) begin
            check({6'h0, w[k+1][25:0]}, {6'h0, hits[k].hits,
                  hits[k].channel, hits[k].phase, hits[k].timeVal});
            check({31'h0, ^w[k+1]}, 32'h0);
        end
        check({31'h0, ended}, 32'h1);
    endtask : test_readout

    task automatic test_full;
        repeat (7) store(0);
        check({31'h0, bufFull}, 32'h1);
        check({31'h0, buffering_in_progress}, 32'h1);
        store(0);
        reg_rd(fbeb_pkg::SA_PTRS, 32'h00000000);
        reg_wr(fbeb_pkg::SA_CTRL0, 32'h00000400);
        reg_rd(fbeb_pkg::SA_PTRS, 32'h00000100);
        check({31'h0, bufFull}, 32'h0);
    endtask : test_full

    task automatic test_raw;
        reg_wr(fbeb_pkg::SA_CTRL0, 32'h00000002);
        reg_wr(fbeb_pkg::SA_WCOUNT, 32'h00000123);
        reg_rd(fbeb_pkg::SA_WCOUNT, 32'h00000123);
        i_fbeb_master.addr(1'b1, {27'h0, GEO}, 1'b0);
        i_fbeb_master.xfer(1'b1, 1'b0, 32'h5, 32'hCAFE0005);
        i_fbeb_master.xfer(1'b0, 1'b0, 32'h5, 32'h0);
        check(i_fbeb_master.rdData, 32'hCAFE0005);
    endtask : test_raw

    initial begin
        n_fail = 0;
        checked = 0;
        hits[0] = '{16'h1234, 1'b1, 7'h05, 2'h1};
        hits[1] = '{16'h00FF, 1'b0, 7'h7F, 2'h3};
        rst = 1'b1;
        blockMode = 1'b0;
        hitIn = '0;
        hitValid = 1'b0;
        hitUnsuppressed = 1'b1;
        eventDone = 1'b0;
        eventPhase = 1'b0;
        edgeEnable = 2'h3;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        test_reset();
        test_addressing();
        test_readout();
        test_full();
        test_raw();
        print_verdict();
    end

    // whole run needs a few hundred cycles; this is ample margin
    initial begin
        #200us;
        n_fail++;
        print_verdict();
    end
endmodule : fastbus_event_buffer_slave_tb
